// [rtl/sdirc_top.v]
/*
  control and indicator logic of a serial video reclocker, with an apb
  register slave for software override and status.
  assumes mclk stands in for the reference clock and that all pins are
  synchronous to it; each control pin comes with a drive flag that is low
  while the pin is left open, so the internal pull can be modelled.
*/
`timescale 1ns/1ps
`include "sdirc_defines.vh"

module sdirc_top #(
  parameter ACQ_CYC = `SDIRC_ACQ_CYC,
  parameter AW      = 8
) (
  input  wire          mclk,
  input  wire          rstn,
  input  wire          psel,
  input  wire          penable,
  input  wire          pwrite,
  input  wire [AW-1:0] paddr,
  input  wire [31:0]   pwdata,
  output wire [31:0]   prdata,
  output wire          pready,
  output wire          pslverr,
  input  wire [1:0]    rateSelPin,
  input  wire [1:0]    rateSelDrv,
  input  wire          muteNPin,
  input  wire          muteNDrv,
  input  wire          bypassPin,
  input  wire          bypassDrv,
  input  wire          clkSelPin,
  input  wire          clkSelDrv,
  input  wire          serialIn,
  input  wire          sigDetect,
  input  wire [2:0]    measRate,
  output wire          lockIndicator,
  output wire          rateClassFlag,
  output wire          mainOutP,
  output wire          mainOutN,
  output wire          auxOutP,
  output wire          auxOutN
);

  // ****************************************************************
  // declarations
  // ****************************************************************

  reg  [31:0] ctrl_ff;
  reg  [31:0] nxt_ctrl;
  reg  [31:0] rdata_ff;
  reg  [31:0] nxt_rdata;
  reg         rdErr_ff;
  reg         nxt_rdErr;
  reg         retimed_ff;
  reg         auxClk_ff;
  reg         nxt_auxClk;
  reg         rateClass_ff;

  wire [1:0]  pinRate;
  wire        pinMuteN;
  wire        pinBypass;
  wire        pinClkSel;
  wire [1:0]  rateMode;
  wire        muteAct;
  wire        bypassAct;
  wire        locked;
  wire        sdRate;
  wire        unsup;
  wire        setupPh;
  wire        accessPh;
  wire        wrHit;

  // ****************************************************************
  // address decode
  // ****************************************************************

  // one place decides whether an offset is mapped, used for read and
  // write alike so the two can never disagree
  function addrHit;
    input [AW-1:0] a;
    begin
      addrHit = (a == `SDIRC_CTRL_OFS) || (a == `SDIRC_STAT_OFS);
    end
  endfunction

  // ****************************************************************
  // pin resolution
  // ****************************************************************

  // an open rate pin reads low through its pull-down
  assign pinRate   = rateSelPin & rateSelDrv;                // RULE1

  // an open mute pin reads high, so outputs run by default
  assign pinMuteN  = muteNDrv ? muteNPin : 1'b1;             // RULE6

  // open bypass and clock select pins read low
  assign pinBypass = bypassPin & bypassDrv;                  // RULE8
  assign pinClkSel = clkSelPin & clkSelDrv;                  // RULE17

  // ****************************************************************
  // mode selection
  // ****************************************************************

  // software may take over the rate code; the pins rule otherwise
  assign rateMode = ctrl_ff[`SDIRC_CTRL_ROVR] ?
                    ctrl_ff[`SDIRC_CTRL_RHI:`SDIRC_CTRL_RLO] :
                    pinRate;                                 // RULE2

  // mute comes from the pin or from the software force bit
  assign muteAct = !pinMuteN || ctrl_ff[`SDIRC_CTRL_FMUTE];  // RULE6

  // forced bypass from pin or software, automatic bypass otherwise;
  // an unsupported rate never reaches lock, so unlocked covers it
  assign bypassAct = pinBypass ||                            // RULE8
                     ctrl_ff[`SDIRC_CTRL_FBYP] ||
                     !locked;                                // RULE9

  // ****************************************************************
  // rate detection and lock
  // ****************************************************************

  // acquisition time is long; shorten ACQ_CYC for simulation
  sdirc_rate_det #(
    .ACQ_CYC (ACQ_CYC),
    .CNT_W   (16)
  ) uRateDet (
    .mclk      (mclk),
    .rstn      (rstn),
    .mode      (rateMode),
    .sigDetect (sigDetect),
    .measRate  (measRate),
    .locked    (locked),
    .sdRate    (sdRate),
    .unsup     (unsup)
  );

  // lock output comes straight from the detector's state flop
  assign lockIndicator = locked;                             // RULE5

  // ****************************************************************
  // retiming path
  // ****************************************************************

  // retiming is modelled as one flop on the reference clock; the raw
  // path skips it, which is what bypass means at this level
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      retimed_ff <= 1'b0;
    end else begin
      retimed_ff <= serialIn;                                // RULE11
    end
  end

  // ****************************************************************
  // recovered clock for the aux output
  // ****************************************************************

  // the clock only runs while locked and selected; it parks low so a
  // later unmute starts from a known phase
  always @* begin
    nxt_auxClk = 1'b0;
    if (locked && pinClkSel) begin
      nxt_auxClk = ~auxClk_ff;                               // RULE17
    end
  end

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      auxClk_ff <= 1'b0;
    end else begin
      auxClk_ff <= nxt_auxClk;
    end
  end

  // ****************************************************************
  // rate class flag
  // ****************************************************************

  // registered one edge after lock moves, forced to hd while unlocked;
  // that one edge is the whole settling time of the flag
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rateClass_ff <= 1'b0;
    end else if (!locked) begin
      rateClass_ff <= 1'b0;                                  // RULE14
    end else begin
      rateClass_ff <= sdRate;                                // RULE13 RULE15
    end
  end

  assign rateClassFlag = rateClass_ff;

  // ****************************************************************
  // output stage
  // ****************************************************************

  // mute priority, bypass routing and aux selection sit in the driver
  sdirc_out_drv uOutDrv (
    .mclk      (mclk),
    .rstn      (rstn),
    .muteAct   (muteAct),                                    // RULE7
    .bypassAct (bypassAct),                                  // RULE10 RULE12
    .clkMode   (pinClkSel),
    .rawData   (serialIn),
    .retimed   (retimed_ff),
    .clkBit    (auxClk_ff),
    .mainOutP  (mainOutP),
    .mainOutN  (mainOutN),
    .auxOutP   (auxOutP),
    .auxOutN   (auxOutN)
  );

  // ****************************************************************
  // apb slave
  // ****************************************************************

  // zero wait states: read data is fetched in the setup phase so that
  // prdata comes from a flop yet is ready in the access phase
  assign setupPh  = psel && !penable;
  assign accessPh = psel && penable;
  assign wrHit    = accessPh && pwrite &&
                    (paddr == `SDIRC_CTRL_OFS);

  // control register: only the documented bits are writable
  always @* begin
    nxt_ctrl = ctrl_ff;
    if (wrHit) begin
      nxt_ctrl = 32'h0000_0000;
      nxt_ctrl[`SDIRC_CTRL_FMUTE] = pwdata[`SDIRC_CTRL_FMUTE];
      nxt_ctrl[`SDIRC_CTRL_FBYP]  = pwdata[`SDIRC_CTRL_FBYP];
      nxt_ctrl[`SDIRC_CTRL_ROVR]  = pwdata[`SDIRC_CTRL_ROVR];
      nxt_ctrl[`SDIRC_CTRL_RHI:`SDIRC_CTRL_RLO] =
        pwdata[`SDIRC_CTRL_RHI:`SDIRC_CTRL_RLO];
    end
  end

  // read mux and error flag, captured in the setup phase
  always @* begin
    nxt_rdata = rdata_ff;
    nxt_rdErr = rdErr_ff;
    if (setupPh) begin
      nxt_rdata = 32'h0000_0000;
      nxt_rdErr = !addrHit(paddr);
      if (!pwrite && paddr == `SDIRC_CTRL_OFS) begin
        nxt_rdata = ctrl_ff;
      end else if (!pwrite && paddr == `SDIRC_STAT_OFS) begin
        nxt_rdata[`SDIRC_STAT_LOCK]  = locked;
        nxt_rdata[`SDIRC_STAT_RCLS]  = rateClass_ff;
        nxt_rdata[`SDIRC_STAT_BYP]   = bypassAct;
        nxt_rdata[`SDIRC_STAT_MUTED] = muteAct;
        nxt_rdata[`SDIRC_STAT_SIG]   = sigDetect;
        nxt_rdata[`SDIRC_STAT_UNSUP] = unsup;
        nxt_rdata[`SDIRC_STAT_MHI:`SDIRC_STAT_MLO] = rateMode;
      end
    end
  end

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ctrl_ff  <= `SDIRC_CTRL_RST;
      rdata_ff <= 32'h0000_0000;
      rdErr_ff <= 1'b0;
    end else begin
      ctrl_ff  <= nxt_ctrl;
      rdata_ff <= nxt_rdata;
      rdErr_ff <= nxt_rdErr;
    end
  end

  // unmapped offsets answer with an error and read as zero
  assign prdata  = rdata_ff;
  assign pready  = 1'b1;
  assign pslverr = accessPh && rdErr_ff;

endmodule

// [rtl/sdirc_defines.vh]
/*
  constants of the serial video reclocker control block: register map,
  field positions, reset values, rate codes and timing figures.
  assumes it is included by bare name from files under rtl/.
*/
// Contract
// RULE1: undriven rate-select pins read as low
// RULE2: decode rate select: auto, 270, HD
// RULE3: auto detection accepts all rates, no harmonics
// RULE4: rate code 11 is test mode
// RULE5: lock high only with signal and lock
// RULE6: mute low mutes outputs; undriven reads high
// RULE7: mute overrides bypass and lock state
// RULE8: bypass high passes data unretimed; default low
// RULE9: auto bypass when unlocked or rate unsupported
// RULE10: unlocked, unmuted: pass data through bypass
// RULE11: locked, unmuted, no bypass: retimed data
// RULE12: unmuted with bypass: raw data always
// RULE13: rate class high for SD, low HD
// RULE14: rate class registered, low while unlocked
// RULE15: rate class valid one reference period later
// RULE16: lock drops within bound after input change
// RULE17: clock select picks aux clock or data copy
// RULE18: board supplies the reference clock
// RULE19: bypass mutes aux output in clock mode
// RULE20: muted output static, legs opposite
// RULE21: 177, 360, 540 Mbps never lock, bypass
`ifndef SDIRC_DEFINES_VH
`define SDIRC_DEFINES_VH

// register byte offsets
`define SDIRC_CTRL_OFS    8'h00
`define SDIRC_STAT_OFS    8'h04

// control register fields
`define SDIRC_CTRL_FMUTE  0
`define SDIRC_CTRL_FBYP   1
`define SDIRC_CTRL_ROVR   2
`define SDIRC_CTRL_RLO    4
`define SDIRC_CTRL_RHI    5
`define SDIRC_CTRL_RST    32'h0000_0000

// status register fields
`define SDIRC_STAT_LOCK   0
`define SDIRC_STAT_RCLS   1
`define SDIRC_STAT_BYP    2
`define SDIRC_STAT_MUTED  3
`define SDIRC_STAT_SIG    4
`define SDIRC_STAT_UNSUP  5
`define SDIRC_STAT_MLO    8
`define SDIRC_STAT_MHI    9

// rate select codes
`define SDIRC_RATE_AUTO   2'h0
`define SDIRC_RATE_SD     2'h1
`define SDIRC_RATE_HD     2'h2
`define SDIRC_RATE_TEST   2'h3

// measured input rate classes from the front end
`define SDIRC_MR_NONE     3'h0
`define SDIRC_MR_143      3'h1
`define SDIRC_MR_177      3'h2
`define SDIRC_MR_270      3'h3
`define SDIRC_MR_360      3'h4
`define SDIRC_MR_540      3'h5
`define SDIRC_MR_1483     3'h6
`define SDIRC_MR_1485     3'h7

// timing: clock rate and printed times
`define SDIRC_CLK_MHZ     20
`define SDIRC_CLK_NS      50
`define SDIRC_TACQ_US     1000
`define SDIRC_ACQ_CYC     (`SDIRC_TACQ_US * `SDIRC_CLK_MHZ)
`define SDIRC_T1_NS       37
`define SDIRC_T1_CYC      ((`SDIRC_T1_NS / `SDIRC_CLK_NS) < 1 ? 1 : \
                           (`SDIRC_T1_NS / `SDIRC_CLK_NS))
`define SDIRC_TLOSS_US    1000

`endif

// [rtl/sdirc_rate_det.v]
/*
  rate detection and lock tracking of the reclocker.
  assumes the front end reports signal presence and a measured rate class
  synchronous to mclk.
*/
`timescale 1ns/1ps
`include "sdirc_defines.vh"

module sdirc_rate_det #(
  parameter ACQ_CYC = `SDIRC_ACQ_CYC,
  parameter CNT_W   = 16
) (
  input  wire       mclk,
  input  wire       rstn,
  input  wire [1:0] mode,
  input  wire       sigDetect,
  input  wire [2:0] measRate,
  output wire       locked,
  output wire       sdRate,
  output wire       unsup
);

  localparam ST_IDLE = 3'h1;
  localparam ST_ACQ  = 3'h2;
  localparam ST_LOCK = 3'h4;
  // the counter keeps only CNT_W bits, so ACQ_CYC must fit in them
  localparam [31:0]      ACQ_M1   = ACQ_CYC - 1;
  localparam [CNT_W-1:0] ACQ_LAST = ACQ_M1[CNT_W-1:0];

  reg [2:0]       state_ff;
  reg [2:0]       nxt_state;
  reg [CNT_W-1:0] cnt_ff;
  reg [CNT_W-1:0] nxt_cnt;
  reg [2:0]       rate_ff;
  reg [2:0]       nxt_rate;

  // harmonics and odd rates map to unsupported classes
  function rateOk;
    input [1:0] m;
    input [2:0] r;
    begin
      case (m)
        `SDIRC_RATE_AUTO: rateOk = (r == `SDIRC_MR_143) ||  // RULE3
                                   (r == `SDIRC_MR_270) ||
                                   (r == `SDIRC_MR_1483) ||
                                   (r == `SDIRC_MR_1485);
        `SDIRC_RATE_SD:   rateOk = (r == `SDIRC_MR_270);     // RULE2
        `SDIRC_RATE_HD:   rateOk = (r == `SDIRC_MR_1483) ||
                                   (r == `SDIRC_MR_1485);
        default:          rateOk = 1'b0;                     // RULE4
      endcase
    end
  endfunction

  wire curOk = rateOk(mode, measRate);

  // a changed rate or lost signal drops lock at once, inside the bound
  always @* begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_rate  = rate_ff;
    case (state_ff)
      ST_IDLE: begin
        nxt_cnt = {CNT_W{1'b0}};
        if (sigDetect && curOk) begin                        // RULE21
          nxt_state = ST_ACQ;
          nxt_rate  = measRate;
        end
      end
      ST_ACQ: begin
        if (!sigDetect || !curOk || measRate != rate_ff) begin
          nxt_state = ST_IDLE;
        end else if (cnt_ff == ACQ_LAST) begin
          nxt_state = ST_LOCK;
        end else begin
          nxt_cnt = cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
        end
      end
      ST_LOCK: begin
        if (!sigDetect || !curOk || measRate != rate_ff) begin
          nxt_state = ST_IDLE;                               // RULE16
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  // state, counter and captured rate
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_ff <= ST_IDLE;
      cnt_ff   <= {CNT_W{1'b0}};
      rate_ff  <= `SDIRC_MR_NONE;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      rate_ff  <= nxt_rate;
    end
  end

  assign locked = (state_ff == ST_LOCK);                     // RULE5
  assign sdRate = (rate_ff == `SDIRC_MR_143) ||              // RULE13
                  (rate_ff == `SDIRC_MR_270);
  assign unsup  = sigDetect && !curOk;

endmodule

// [rtl/sdirc_out_drv.v]
/*
  differential output stage of the reclocker: mute, bypass and aux select.
  assumes all inputs are synchronous to mclk.
*/
`timescale 1ns/1ps

module sdirc_out_drv (
  input  wire mclk,
  input  wire rstn,
  input  wire muteAct,
  input  wire bypassAct,
  input  wire clkMode,
  input  wire rawData,
  input  wire retimed,
  input  wire clkBit,
  output reg  mainOutP,
  output reg  mainOutN,
  output reg  auxOutP,
  output reg  auxOutN
);

  wire mainBit = bypassAct ? rawData : retimed;              // RULE10 RULE11
  wire auxMute = muteAct || (clkMode && bypassAct);          // RULE19
  wire auxBit  = clkMode ? clkBit : mainBit;                 // RULE17

  // muted legs sit static and opposite, never toggling
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      mainOutP <= 1'b0;
      mainOutN <= 1'b1;
      auxOutP  <= 1'b0;
      auxOutN  <= 1'b1;
    end else begin
      if (muteAct) begin                                     // RULE7
        mainOutP <= 1'b0;                                    // RULE20
        mainOutN <= 1'b1;
      end else begin
        mainOutP <= mainBit;                                 // RULE12
        mainOutN <= ~mainBit;
      end
      if (auxMute) begin
        auxOutP <= 1'b0;                                     // RULE20
        auxOutN <= 1'b1;
      end else begin
        auxOutP <= auxBit;
        auxOutN <= ~auxBit;
      end
    end
  end

endmodule

// [verif/sdirc_assertions.sv]
/*
  checker of the reclocker control block: output path, lock and rate class.
  assumes it is bound to sdirc_top and sees only the ports it names.
*/
`timescale 1ns/1ps

module sdirc_checker #(
  parameter ACQ_CYC = 8,
  parameter AW      = 8
) (
  input wire          mclk,
  input wire          rstn,
  input wire          psel,
  input wire          penable,
  input wire          pwrite,
  input wire [AW-1:0] paddr,
  input wire [31:0]   pwdata,
  input wire          pready,
  input wire          muteNPin,
  input wire          muteNDrv,
  input wire          bypassPin,
  input wire          bypassDrv,
  input wire          clkSelPin,
  input wire          clkSelDrv,
  input wire          serialIn,
  input wire          sigDetect,
  input wire [2:0]    measRate,
  input wire          lockIndicator,
  input wire          rateClassFlag,
  input wire          mainOutP,
  input wire          mainOutN,
  input wire          auxOutP,
  input wire          auxOutN
);
  // ****************************************
  // effective controls
  // ****************************************
  reg [1:0]  ctlMir_ff;
  reg [2:0]  prevRate_ff;
  reg [15:0] stCnt_ff;
  // open pins fall back to their pulls
  wire muteEff = (muteNDrv & ~muteNPin) | ctlMir_ff[0];
  wire bypEff  = (bypassDrv & bypassPin) | ctlMir_ff[1] | ~lockIndicator;
  wire clkEff  = clkSelDrv & clkSelPin;
  wire sdRate  = (measRate == 3'h1) || (measRate == 3'h3);
  wire badRate = (measRate == 3'h2) || (measRate == 3'h4) ||
                 (measRate == 3'h5);

  // force bits mirrored from apb writes; steady-input counter saturates
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ctlMir_ff   <= 2'h0;
      prevRate_ff <= 3'h0;
      stCnt_ff    <= 16'h0;
    end else begin
      if (psel && penable && pwrite && pready && paddr == {AW{1'b0}})
        ctlMir_ff <= pwdata[1:0];
      prevRate_ff <= measRate;
      if (!sigDetect || measRate != prevRate_ff)
        stCnt_ff <= 16'h0;
      else if (stCnt_ff != 16'hFFFF)
        stCnt_ff <= stCnt_ff + 16'h1;
    end
  end

  // ****************************************
  // properties
  // ****************************************
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);

  sequence outMuted;
    !mainOutP && mainOutN;
  endsequence
  sequence auxMuted;
    !auxOutP && auxOutN;
  endsequence

  mute_main_a: assert property (muteEff |=> outMuted)
    else $error("main output not muted");
  mute_aux_a: assert property (muteEff |=> auxMuted)
    else $error("aux output not muted");
  legs_apart_a: assert property (mainOutP != mainOutN &&
    auxOutP != auxOutN) else $error("output legs equal");
  bypass_path_a: assert property (!muteEff && bypEff
    |=> mainOutP == $past(serialIn)) else $error("bypass data wrong");
  retime_path_a: assert property (!muteEff && !bypEff
    |=> mainOutP == $past(serialIn, 2)) else $error("retimed data wrong");
  aux_copy_a: assert property (!muteEff && !clkEff
    |=> auxOutP == mainOutP) else $error("aux copy differs");
  aux_clkmute_a: assert property (!muteEff && clkEff && bypEff
    |=> auxMuted) else $error("aux clock not muted");
  class_low_a: assert property (!lockIndicator
    |=> !rateClassFlag) else $error("rate class high unlocked");
  class_value_a: assert property (lockIndicator && $stable(measRate)
    |=> rateClassFlag == $past(sdRate)) else $error("rate class wrong");
  lock_drop_a: assert property (!sigDetect || badRate
    |=> !lockIndicator) else $error("lock held without signal");
  lock_acq_a: assert property ($rose(lockIndicator)
    |-> stCnt_ff >= ACQ_CYC) else $error("lock came too early");
  zero_wait_a: assert property (psel && penable |-> pready)
    else $error("access phase not ready");
endmodule

bind sdirc_top sdirc_checker #(.ACQ_CYC(ACQ_CYC), .AW(AW)) uChk (
  .mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .muteNPin(muteNPin), .muteNDrv(muteNDrv), .bypassPin(bypassPin),
  .bypassDrv(bypassDrv), .clkSelPin(clkSelPin), .clkSelDrv(clkSelDrv),
  .serialIn(serialIn), .sigDetect(sigDetect), .measRate(measRate),
  .lockIndicator(lockIndicator), .rateClassFlag(rateClassFlag),
  .mainOutP(mainOutP), .mainOutN(mainOutN), .auxOutP(auxOutP),
  .auxOutN(auxOutN));

// [verif/sdirc_front_model.sv]
/*
  model of the equalizer side: serial samples, carrier detect, rate class.
  assumes the bench changes present and rateCls just after a rising edge.
*/
`timescale 1ns/1ps

module sdirc_front_model (
  input  wire       mclk,
  input  wire       present,
  input  wire [2:0] rateCls,
  output reg        serialIn  = 1'b0,
  output reg        sigDetect = 1'b0,
  output reg  [2:0] measRate  = 3'h0
);
  // ****************************************
  // stream source
  // ****************************************
  reg [6:0] lfsr_ff = 7'h5A;

  // no carrier: line toggles so a stale level never passes for data
  always @(posedge mclk) begin
    lfsr_ff   <= {lfsr_ff[5:0], lfsr_ff[6] ^ lfsr_ff[5]};
    sigDetect <= present;
    measRate  <= present ? rateCls : 3'h0;
    serialIn  <= present ? lfsr_ff[6] : ~serialIn;
  end
endmodule

// [verif/test_sdirc_reclocker_control.sv]
/*
  bench of the reclocker control block: registers, rate decode, lock,
  rate class, mute and bypass.
  assumes sdirc_top, the front model and the bound checker.
*/
`timescale 1ns/1ps
`include "sdirc_defines.vh"

module test_sdirc_reclocker_control;
  // ****************************************
  // signals
  // ****************************************
  localparam ACQ = 8;
  logic        mclk = 1'b0, rstn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdQ;
  logic        pready, pslverr, rdErr, q1, sup;
  logic [1:0]  rateSelPin = 2'h0, rateSelDrv = 2'h0;
  logic        muteNPin = 1'b1, muteNDrv = 1'b0;
  logic        bypassPin = 1'b0, bypassDrv = 1'b0;
  logic        clkSelPin = 1'b0, clkSelDrv = 1'b0;
  logic        serialIn, sigDetect, lockIndicator, rateClassFlag;
  logic [2:0]  measRate, rateCls = 3'h0;
  logic        mainOutP, mainOutN, auxOutP, auxOutN, present = 1'b0;
  logic [2:0]  rates [7] = '{3'h1, 3'h3, 3'h6, 3'h7, 3'h2, 3'h4, 3'h5};
  int          failCount = 0, numChecks = 0, cyc = 0;

  sdirc_top #(.ACQ_CYC(ACQ)) uut (
    .mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rateSelPin(rateSelPin),
    .rateSelDrv(rateSelDrv), .muteNPin(muteNPin), .muteNDrv(muteNDrv),
    .bypassPin(bypassPin), .bypassDrv(bypassDrv), .clkSelPin(clkSelPin),
    .clkSelDrv(clkSelDrv), .serialIn(serialIn), .sigDetect(sigDetect),
    .measRate(measRate), .lockIndicator(lockIndicator),
    .rateClassFlag(rateClassFlag), .mainOutP(mainOutP),
    .mainOutN(mainOutN), .auxOutP(auxOutP), .auxOutN(auxOutN));

  sdirc_front_model fm (.mclk(mclk), .present(present), .rateCls(rateCls),
    .serialIn(serialIn), .sigDetect(sigDetect), .measRate(measRate));

  // reference clock, 20 MHz
  always #25 mclk = ~mclk;

  // ****************************************
  // tasks
  // ****************************************
  // one apb transfer; waits for pready, only the hang guard ends a wait
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rdQ     = prdata;
    rdErr   = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task chkWord(input string nm, input logic [31:0] e, input logic [31:0] g);
    numChecks++;
    if (g !== e) begin
      failCount++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task chkBit(input string nm, input logic e, input logic g);
    chkWord(nm, {31'h0, e}, {31'h0, g});
  endtask

  task finishTest;
    if (failCount == 0 && numChecks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // hang guard, well above the planned run
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      failCount++;
      finishTest();
    end
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    apb(1'b0, `SDIRC_CTRL_OFS, 32'h0);
    chkWord("ctrl reset", 32'h0, rdQ);
    apb(1'b1, `SDIRC_CTRL_OFS, 32'hFFFF_FFFF);
    apb(1'b0, `SDIRC_CTRL_OFS, 32'h0);
    chkWord("ctrl rw", 32'h37, rdQ);
    apb(1'b1, `SDIRC_CTRL_OFS, 32'h0);
    apb(1'b1, `SDIRC_STAT_OFS, 32'hFFFF_FFFF);
    apb(1'b0, `SDIRC_STAT_OFS, 32'h0);
    chkWord("stat idle", 32'h4, rdQ & 32'h31F);
    apb(1'b0, 8'h08, 32'h0);
    chkBit("unmapped err", 1'b1, rdErr);
    chkWord("unmapped data", 32'h0, rdQ);
    // every code against every rate class but none; 11 must never lock
    present    <= 1'b1;
    rateSelDrv <= 2'h3;
    for (int c = 0; c < 4; c++) begin
      for (int r = 0; r < 7; r++) begin
        rateSelPin <= c[1:0];
        rateCls    <= rates[r];
        repeat (ACQ + 6) @(posedge mclk);
        sup = (c == 0 && r < 4) || (c == 1 && r == 1) ||
              (c == 2 && (r == 2 || r == 3));
        chkBit("lock", sup, lockIndicator);
        chkBit("class", sup && r < 2, rateClassFlag);
      end
    end
    // open pins: auto rate, unmuted, no bypass, data copy on aux
    rateSelPin <= 2'h3;
    rateSelDrv <= 2'h0;
    rateCls    <= 3'h3;
    repeat (ACQ + 6) @(posedge mclk);
    apb(1'b0, `SDIRC_STAT_OFS, 32'h0);
    chkWord("stat open", 32'h13, rdQ & 32'h31F);
    clkSelPin <= 1'b1;
    clkSelDrv <= 1'b1;
    repeat (3) @(posedge mclk);
    q1 = auxOutP;
    @(posedge mclk);
    chkBit("aux clock", ~q1, auxOutP);
    bypassPin <= 1'b1;
    bypassDrv <= 1'b1;
    repeat (3) @(posedge mclk);
    chkBit("aux muted", 1'b0, auxOutP);
    apb(1'b0, `SDIRC_STAT_OFS, 32'h0);
    chkWord("stat bypass", 32'h17, rdQ & 32'h31F);
    muteNPin <= 1'b0;
    muteNDrv <= 1'b1;
    repeat (3) @(posedge mclk);
    chkBit("main p", 1'b0, mainOutP);
    chkBit("main n", 1'b1, mainOutN);
    muteNDrv  <= 1'b0;
    bypassDrv <= 1'b0;
    apb(1'b0, `SDIRC_STAT_OFS, 32'h0);
    chkWord("stat pulls", 32'h13, rdQ & 32'h31F);
    apb(1'b1, `SDIRC_CTRL_OFS, 32'h3);
    apb(1'b0, `SDIRC_STAT_OFS, 32'h0);
    chkWord("stat forced", 32'hC, rdQ & 32'hC);
    apb(1'b1, `SDIRC_CTRL_OFS, 32'h24);
    repeat (4) @(posedge mclk);
    chkBit("lock hd on sd", 1'b0, lockIndicator);
    apb(1'b1, `SDIRC_CTRL_OFS, 32'h0);
    repeat (ACQ + 6) @(posedge mclk);
    chkBit("relock", 1'b1, lockIndicator);
    present <= 1'b0;
    repeat (3) @(posedge mclk);
    chkBit("lock lost", 1'b0, lockIndicator);
    // the flag is cleared one edge after lock is seen low
    @(posedge mclk);
    chkBit("class lost", 1'b0, rateClassFlag);
    finishTest();
  end
endmodule
